// [common/eef_pkg.sv]
package eef_pkg;
    // ==========================================
    // Register offsets
    localparam logic [7:0] EEF_FLAG_OFS = 8'h00;
    localparam logic [7:0] EEF_CLR_OFS = 8'h04;
    localparam logic [7:0] EEF_EN_OFS = 8'h08;
    localparam logic [7:0] EEF_STAT_OFS = 8'h0C;
    localparam logic [7:0] EEF_STCLR_OFS = 8'h10;
    localparam logic [7:0] EEF_PHYEN_OFS = 8'h14;
    localparam logic [7:0] EEF_PHYFLAG_OFS = 8'h18;
    localparam logic [7:0] EEF_CTRL_OFS = 8'h1C;
    localparam logic [7:0] EEF_PKT_OFS = 8'h20;
    localparam logic [7:0] EEF_MAXLEN_OFS = 8'h24;
    // ==========================================
    // Field positions
    localparam int EEF_B_RXERR = 0;
    localparam int EEF_B_TXERR = 1;
    localparam int EEF_B_TXDONE = 3;
    localparam int EEF_B_LINK = 4;
    localparam int EEF_B_COPY = 5;
    localparam int EEF_B_PEND = 6;
    localparam int EEF_B_GLOBAL = 7;
    localparam int EEF_B_AGG = 7;
    localparam int EEF_B_LATE = 4;
    localparam int EEF_B_ABORT = 1;
    localparam int EEF_B_PLINK = 4;
    localparam int EEF_B_PGLOB_EN = 1;
    localparam int EEF_B_PGLOB_FL = 2;
    localparam int EEF_B_TXREQ = 0;
    localparam int EEF_B_COPYGO = 1;
    localparam int EEF_B_FDX = 2;
    localparam int EEF_B_HUGE = 3;
    localparam int EEF_B_FOREVER = 4;
    localparam int EEF_B_PKTDEC = 0;
    localparam logic [7:0] EEF_EN_MASK = 8'hFB;
    localparam logic [15:0] EEF_PHYEN_MASK = 16'h0012;
    // ==========================================
    // Reset values and limits
    localparam logic [7:0] EEF_EN_RST = 8'h00;
    localparam logic [15:0] EEF_PHYEN_RST = 16'h0000;
    localparam logic [7:0] EEF_CTRL_RST = 8'h00;
    localparam logic [15:0] EEF_MAXLEN_RST = 16'h05EE;
    localparam logic [7:0] EEF_PKT_MAX = 8'hFF;
    localparam logic [1:0] EEF_RESP_OK = 2'h0;
    localparam logic [1:0] EEF_RESP_ERR = 2'h2;
    // ==========================================
    // Timing
    localparam int EEF_CLK_PERIOD_NS = 25;
    localparam int EEF_FOREVER_A_LIMIT_NS = 2428700;
    localparam int EEF_FOREVER_A_CYC = EEF_FOREVER_A_LIMIT_NS / EEF_CLK_PERIOD_NS;
    // ==========================================
    // Carriers
    typedef struct packed {
        logic frame_end;
        logic no_space;
    } eef_rx_evt_t;
    typedef struct packed {
        logic completed;
        logic retry_exceeded;
        logic late_window;
        logic coll_after64;
        logic medium_busy;
        logic len_valid;
        logic [15:0] frame_len;
        logic pp_override;
        logic pp_huge;
    } eef_tx_evt_t;
endpackage

// [core/eef_sticky.sv]
`timescale 1ns/1ps
`default_nettype none
module eef_sticky
    import eef_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Set and clear
    input wire logic set,
    input wire logic clr,
    // Flag
    output logic q
);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= 1'b0;
        end else if (set) begin
            q <= 1'b1;
        end else if (clr) begin
            q <= 1'b0;
        end
    end
endmodule // eef_sticky
`default_nettype wire

// [core/eef_event_flags.sv]
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module eef_event_flags
    import eef_pkg::*;
#(
    parameter int FOREVER_A_CYC = EEF_FOREVER_A_CYC
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Datapath events
    input wire eef_rx_evt_t rx_evt,
    input wire eef_tx_evt_t tx_evt,
    input wire logic [12:0] tx_end_pointer,
    input wire logic copy_finished,
    input wire logic phy_link_event,
    // Datapath controls
    output logic tx_request,
    output logic copy_go,
    output logic rx_frame_abort,
    output logic tx_status_wr,
    output logic [12:0] tx_status_addr,
    // Host request pin
    output logic irq_n_pin
);
    // ==========================================
    // Bus handshake
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    wire wr_fire = awvalid && awready_q && wvalid && wready_q;
    wire rd_fire = arvalid && arready_q;
    wire wr_b0 = wr_fire && wstrb[0];
    wire wr_b1 = wr_fire && wstrb[1];
    wire wr_clr = wr_b0 && (awaddr == EEF_CLR_OFS);
    wire wr_en = wr_b0 && (awaddr == EEF_EN_OFS);
    wire wr_stclr = wr_b0 && (awaddr == EEF_STCLR_OFS);
    wire wr_phyen = wr_b0 && (awaddr == EEF_PHYEN_OFS);
    wire wr_ctrl = wr_b0 && (awaddr == EEF_CTRL_OFS);
    wire wr_pkt = wr_b0 && (awaddr == EEF_PKT_OFS);
    wire wr_max = wr_fire && (awaddr == EEF_MAXLEN_OFS);
    wire phy_read = rd_fire && (araddr == EEF_PHYFLAG_OFS);
    wire wr_mapped = (awaddr == EEF_FLAG_OFS) || (awaddr == EEF_CLR_OFS) ||
        (awaddr == EEF_EN_OFS) || (awaddr == EEF_STAT_OFS) || (awaddr == EEF_STCLR_OFS) ||
        (awaddr == EEF_PHYEN_OFS) || (awaddr == EEF_PHYFLAG_OFS) ||
        (awaddr == EEF_CTRL_OFS) || (awaddr == EEF_PKT_OFS) || (awaddr == EEF_MAXLEN_OFS);
    // ==========================================
    // Control registers
    logic [7:0] en_q, ctrl_q, pkt_cnt_q;
    logic [15:0] phy_en_q, max_len_q;
    logic tx_req_prev_q, copy_prev_q;
    logic [23:0] forever_a_cnt_q;
    wire global_en = en_q[EEF_B_GLOBAL];
    wire full_duplex = ctrl_q[EEF_B_FDX];
    wire tx_req = ctrl_q[EEF_B_TXREQ];
    wire copy_on = ctrl_q[EEF_B_COPYGO];
    wire phy_both_en = phy_en_q[EEF_B_PLINK] && phy_en_q[EEF_B_PGLOB_EN];
    // ==========================================
    // Transmit abort causes
    wire huge_ok = ctrl_q[EEF_B_HUGE] || (tx_evt.pp_override && tx_evt.pp_huge);
    wire oversize = tx_evt.len_valid && (tx_evt.frame_len > max_len_q) && !huge_ok;
    wire forever_a_hit = tx_req && tx_evt.medium_busy && !ctrl_q[EEF_B_FOREVER] &&
        (forever_a_cnt_q == 24'(FOREVER_A_CYC - 1));
    wire shared_fault = tx_evt.retry_exceeded || tx_evt.late_window ||
        tx_evt.coll_after64 || forever_a_hit;
    wire tx_abort = tx_req && (oversize || (!full_duplex && shared_fault));
    wire tx_fall = tx_req_prev_q && !tx_req;
    wire copy_fall = copy_prev_q && !copy_on;
    // ==========================================
    // Receive accounting
    wire rx_full = rx_evt.no_space || (pkt_cnt_q == EEF_PKT_MAX);
    wire rx_drop = rx_evt.frame_end && rx_full;
    wire rx_store = rx_evt.frame_end && !rx_full;
    wire pkt_dec = wr_pkt && wdata[EEF_B_PKTDEC] && (pkt_cnt_q != 8'h00);
    wire [7:0] pkt_cnt_d = pkt_cnt_q + {7'h00, rx_store} - {7'h00, pkt_dec};
    wire rx_pending = pkt_cnt_q != 8'h00;
    // ==========================================
    // Sticky flags
    logic rx_error, tx_error, tx_done, copy_done, late_col, tx_abort_flag;
    logic phy_link_flag, phy_glob_flag, link_flag;
    wire clr_rx = wr_clr && wdata[EEF_B_RXERR];
    eef_sticky u_rx_err (
        .aclk(aclk), .aresetn(aresetn), .set(rx_drop), .clr(clr_rx), .q(rx_error));
    eef_sticky u_tx_err (
        .aclk(aclk), .aresetn(aresetn), .set(tx_abort),
        .clr(wr_clr && wdata[EEF_B_TXERR]), .q(tx_error));
    eef_sticky u_tx_done (
        .aclk(aclk), .aresetn(aresetn), .set(tx_abort || tx_fall),
        .clr(wr_clr && wdata[EEF_B_TXDONE]), .q(tx_done));
    eef_sticky u_copy (
        .aclk(aclk), .aresetn(aresetn), .set(copy_fall),
        .clr(wr_clr && wdata[EEF_B_COPY]), .q(copy_done));
    eef_sticky u_late (
        .aclk(aclk), .aresetn(aresetn), .set(tx_req && !full_duplex && tx_evt.coll_after64),
        .clr(wr_stclr && wdata[EEF_B_LATE]), .q(late_col));
    eef_sticky u_abort (
        .aclk(aclk), .aresetn(aresetn), .set(tx_abort),
        .clr(wr_stclr && wdata[EEF_B_ABORT]), .q(tx_abort_flag));
    eef_sticky u_plink (
        .aclk(aclk), .aresetn(aresetn), .set(phy_link_event),
        .clr(phy_read), .q(phy_link_flag));
    eef_sticky u_pglob (
        .aclk(aclk), .aresetn(aresetn),
        .set(phy_both_en && (phy_link_event || (phy_link_flag && !phy_read))),
        .clr(phy_read), .q(phy_glob_flag));
    eef_sticky u_link (
        .aclk(aclk), .aresetn(aresetn), .set(phy_glob_flag && phy_both_en && !phy_read),
        .clr(phy_read), .q(link_flag));
    // ==========================================
    // Flag, status and request
    wire [7:0] flags = {1'b0, rx_pending, copy_done, link_flag, tx_done, 1'b0,
        tx_error, rx_error};
    wire aggregate = |(flags & en_q & 8'h7B);
    wire [7:0] status = {aggregate, 2'b00, late_col, 2'b00, tx_abort_flag, 1'b0};
    wire [15:0] phy_flags = {11'h000, phy_link_flag, 1'b0, phy_glob_flag, 2'b00};
    logic irq_n_q, rx_abort_q, tx_stat_q;
    logic [12:0] tx_stat_addr_q;
    logic [31:0] rd_word;
    always_comb begin
        unique case (araddr)
            EEF_FLAG_OFS: rd_word = {24'h000000, flags};
            EEF_EN_OFS: rd_word = {24'h000000, en_q};
            EEF_STAT_OFS: rd_word = {24'h000000, status};
            EEF_PHYEN_OFS: rd_word = {16'h0000, phy_en_q};
            EEF_PHYFLAG_OFS: rd_word = {16'h0000, phy_flags};
            EEF_CTRL_OFS: rd_word = {24'h000000, ctrl_q};
            EEF_PKT_OFS: rd_word = {24'h000000, pkt_cnt_q};
            EEF_MAXLEN_OFS: rd_word = {16'h0000, max_len_q};
            default: rd_word = 32'h00000000;
        endcase
    end
    wire rd_mapped = (araddr == EEF_FLAG_OFS) || (araddr == EEF_CLR_OFS) ||
        (araddr == EEF_EN_OFS) || (araddr == EEF_STAT_OFS) || (araddr == EEF_STCLR_OFS) ||
        (araddr == EEF_PHYEN_OFS) || (araddr == EEF_PHYFLAG_OFS) ||
        (araddr == EEF_CTRL_OFS) || (araddr == EEF_PKT_OFS) || (araddr == EEF_MAXLEN_OFS);
    // ==========================================
    // Bus state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= EEF_RESP_OK;
        end else begin
            awready_q <= awvalid && wvalid && !awready_q && !bvalid_q;
            wready_q <= awvalid && wvalid && !awready_q && !bvalid_q;
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_mapped ? EEF_RESP_OK : EEF_RESP_ERR;
            end else if (bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= EEF_RESP_OK;
        end else begin
            arready_q <= arvalid && !arready_q && !rvalid_q;
            if (rd_fire) begin
                rvalid_q <= 1'b1;
                rdata_q <= rd_word;
                rresp_q <= rd_mapped ? EEF_RESP_OK : EEF_RESP_ERR;
            end else if (rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end
    // ==========================================
    // Control state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            en_q <= EEF_EN_RST;
            phy_en_q <= EEF_PHYEN_RST;
            max_len_q <= EEF_MAXLEN_RST;
            pkt_cnt_q <= 8'h00;
        end else begin
            if (wr_en) en_q <= wdata[7:0] & EEF_EN_MASK;
            if (wr_phyen) phy_en_q <= wdata[15:0] & EEF_PHYEN_MASK;
            if (wr_max && wr_b0) max_len_q[7:0] <= wdata[7:0];
            if (wr_max && wr_b1) max_len_q[15:8] <= wdata[15:8];
            pkt_cnt_q <= pkt_cnt_d;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= EEF_CTRL_RST;
        end else begin
            if (wr_ctrl) ctrl_q <= wdata[7:0] & 8'h1F;
            if (tx_abort || tx_evt.completed) ctrl_q[EEF_B_TXREQ] <= 1'b0;
            if (copy_finished) ctrl_q[EEF_B_COPYGO] <= 1'b0;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_req_prev_q <= 1'b0;
            copy_prev_q <= 1'b0;
            forever_a_cnt_q <= 24'h000000;
        end else begin
            tx_req_prev_q <= tx_req;
            copy_prev_q <= copy_on;
            if (tx_req && tx_evt.medium_busy && !full_duplex && !forever_a_hit)
                forever_a_cnt_q <= forever_a_cnt_q + 24'h000001;
            else
                forever_a_cnt_q <= 24'h000000;
        end
    end
    // ==========================================
    // Outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_n_q <= 1'b1;
            rx_abort_q <= 1'b0;
            tx_stat_q <= 1'b0;
            tx_stat_addr_q <= 13'h0000;
        end else begin
            irq_n_q <= !(global_en && aggregate);
            rx_abort_q <= rx_drop;
            tx_stat_q <= tx_abort;
            if (tx_abort) tx_stat_addr_q <= tx_end_pointer + 13'h0001;
        end
    end
    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign tx_request = tx_req;
    assign copy_go = copy_on;
    assign rx_frame_abort = rx_abort_q;
    assign tx_status_wr = tx_stat_q;
    assign tx_status_addr = tx_stat_addr_q;
    assign irq_n_pin = irq_n_q;
    // ==========================================
    // Checks
    chk_rx_drop_err: assert property (@(posedge aclk) disable iff (!aresetn)
        rx_drop |=> rx_error && rx_frame_abort)
        else $error("receive drop did not set error and abort");
    chk_rx_err_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        rx_error && !clr_rx |=> rx_error)
        else $error("receive error dropped without clear");
    chk_irq_asserted: assert property (@(posedge aclk) disable iff (!aresetn)
        global_en && (flags[EEF_B_TXERR] && en_q[EEF_B_TXERR]) |=> !irq_n_pin)
        else $error("request pin not low for enabled flag");
    chk_irq_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
        !global_en |=> irq_n_pin)
        else $error("request pin low with global enable off");
    chk_abort_effects: assert property (@(posedge aclk) disable iff (!aresetn)
        tx_abort |=> !tx_request && tx_abort_flag && tx_status_wr &&
            tx_status_addr == $past(tx_end_pointer) + 13'h0001)
        else $error("transmit abort side effects missing");
    chk_err_sets_done: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(tx_error) |-> $rose(tx_done) || $past(tx_done))
        else $error("transmit error without transmit done");
    chk_tx_fall_done: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(tx_request) |=> tx_done)
        else $error("transmit request fall did not set done");
    chk_copy_fall_done: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(copy_go) |=> copy_done)
        else $error("copy go fall did not set copy done");
    chk_fdx_cause: assert property (@(posedge aclk) disable iff (!aresetn)
        full_duplex && tx_abort |-> oversize)
        else $error("full duplex abort without oversize frame");
    chk_pend_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        pkt_cnt_q == 8'h01 && pkt_dec && !rx_store |=> !flags[EEF_B_PEND] ##1 irq_n_pin || en_q[EEF_B_PEND] == 1'b0 || aggregate)
        else $error("pending flag did not follow count to zero");
    chk_wake_frame: assert property (@(posedge aclk) disable iff (!aresetn)
        pkt_cnt_q == 8'h00 && rx_store && !pkt_dec && global_en && en_q[EEF_B_PEND]
        |=> flags[EEF_B_PEND] && status[EEF_B_AGG] ##1 !irq_n_pin)
        else $error("wake frame did not raise request");
    chk_phy_rd_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        phy_read && !phy_link_event |=> !link_flag && !phy_glob_flag && !phy_link_flag)
        else $error("PHY flag read did not clear link flags");
    chk_link_gated: assert property (@(posedge aclk) disable iff (!aresetn)
        !phy_both_en && !link_flag |=> !link_flag)
        else $error("link flag set without PHY enables");
    chk_set_wins: assert property (@(posedge aclk) disable iff (!aresetn)
        rx_drop && clr_rx |=> rx_error)
        else $error("host clear beat hardware set");
endmodule // eef_event_flags
`default_nettype wire

// [bench/eef_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module eef_host_model (
    // Clock
    input wire logic aclk,
    // Write channels
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    // Read channels
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    initial begin
        {awaddr, awvalid, wdata, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
        wstrb = 4'hF;
    end
    // ==========================================
    // Write; flags are cleared through the clear registers, except the link and PHY flags (PHY flag read) and the pending flag (packet count)
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ad, wd;
        ad = 1'h0;
        wd = 1'h0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            ad = ad || (awready === 1'h1);
            wd = wd || (wready === 1'h1);
            if (ad) awvalid <= 1'h0;
            if (wd) wvalid <= 1'h0;
        end
        do @(posedge aclk); while (bvalid !== 1'h1);
        r = bresp;
        bready <= 1'h0;
    endtask
    // ==========================================
    // Read
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(posedge aclk); while (arready !== 1'h1);
        arvalid <= 1'h0;
        do @(posedge aclk); while (rvalid !== 1'h1);
        d = rdata;
        r = rresp;
        rready <= 1'h0;
    endtask
endmodule // eef_host_model
`default_nettype wire

// [bench/eef_event_flags_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module eef_event_flags_bench import eef_pkg::*;;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
    logic rvalid, rready, copy_finished, phy_link_event, tx_request, copy_go;
    logic rx_frame_abort, tx_status_wr, irq_n_pin;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd_d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rd_r;
    logic [12:0] tx_end_pointer, tx_status_addr;
    eef_rx_evt_t rx_evt;
    eef_tx_evt_t tx_evt;
    int failures, n_checks, n_drop, n_stat;
    localparam logic [23:0] CAUSE [4] = '{24'h400000, 24'h200000, 24'h100000, 24'h041800};
    eef_event_flags #(.FOREVER_A_CYC(20)) uut (.aclk, .aresetn, .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .rx_evt, .tx_evt, .tx_end_pointer,
        .copy_finished, .phy_link_event, .tx_request, .copy_go, .rx_frame_abort,
        .tx_status_wr, .tx_status_addr, .irq_n_pin);
    eef_host_model host (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready);
    initial aclk = 1'h0;
    always #12.5 aclk = ~aclk;
    always @(posedge aclk) begin
        n_drop <= n_drop + int'(rx_frame_abort === 1'h1);
        n_stat <= n_stat + int'(tx_status_wr === 1'h1);
    end
    // ==========================================
    // Access and compare tasks
    task automatic complete_run;
        if (failures == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            $display("unexpected %s: expected %h, seen %h", n, e, g);
            failures++;
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        host.rd(a, rd_d, rd_r);
        chk("read data", e, rd_d);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.wr(a, d, rd_r);
        chk("write response", 32'h0, {30'h0, rd_r});
    endtask
    task automatic pin(input logic e);
        repeat (3) @(posedge aclk);
        chk("irq_n_pin", {31'h0, e}, {31'h0, irq_n_pin});
    endtask
    task automatic tx_hold(input logic [23:0] e, input int n);
        @(posedge aclk);
        tx_evt <= eef_tx_evt_t'(e);
        repeat (n) @(posedge aclk);
        tx_evt <= '0;
    endtask
    task automatic rx_frame(input logic ns);
        @(posedge aclk);
        rx_evt <= eef_rx_evt_t'({1'h1, ns});
        @(posedge aclk);
        rx_evt <= '0;
    endtask
    task automatic phy_pulse;
        @(posedge aclk);
        phy_link_event <= 1'h1;
        @(posedge aclk);
        phy_link_event <= 1'h0;
    endtask
    // ==========================================
    // Watchdog
    initial begin
        repeat (20000) @(posedge aclk);
        failures++;
        complete_run;
    end
    // ==========================================
    // Tests
    initial begin
        {aresetn, copy_finished, phy_link_event, failures, n_checks, n_drop, n_stat} = '0;
        rx_evt = '0;
        tx_evt = '0;
        tx_end_pointer = 13'h0ABC;
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        rc(EEF_FLAG_OFS, 32'h0);
        rc(EEF_MAXLEN_OFS, {16'h0, EEF_MAXLEN_RST});
        host.rd(8'h40, rd_d, rd_r);
        chk("unmapped response", {30'h0, EEF_RESP_ERR}, {30'h0, rd_r});
        wr(EEF_EN_OFS, 32'hFF);
        rc(EEF_EN_OFS, 32'hFB);
        wr(EEF_EN_OFS, 32'h7B);
        wr(EEF_CTRL_OFS, 32'h2);
        wr(EEF_CTRL_OFS, 32'h0);
        rc(EEF_FLAG_OFS, 32'h20);
        pin(1'h1);
        rc(EEF_STAT_OFS, 32'h80);
        wr(EEF_EN_OFS, 32'hFB);
        pin(1'h0);
        wr(EEF_CLR_OFS, 32'h20);
        pin(1'h1);
        wr(EEF_CTRL_OFS, 32'h2);
        @(posedge aclk);
        copy_finished <= 1'h1;
        @(posedge aclk);
        copy_finished <= 1'h0;
        pin(1'h0);
        chk("copy_go", 32'h0, {31'h0, copy_go});
        wr(EEF_CLR_OFS, 32'h20);
        for (int i = 0; i < 4; i++) begin
            wr(EEF_CTRL_OFS, 32'h1);
            tx_hold(CAUSE[i], 1);
            rc(EEF_FLAG_OFS, 32'h0A);
            chk("tx_request", 32'h0, {31'h0, tx_request});
            wr(EEF_CLR_OFS, 32'h0A);
            wr(EEF_STCLR_OFS, 32'h12);
        end
        chk("tx_status_addr", 32'h0ABD, {19'h0, tx_status_addr});
        wr(EEF_CTRL_OFS, 32'h11);
        tx_hold(24'h080000, 30);
        rc(EEF_FLAG_OFS, 32'h0);
        wr(EEF_CTRL_OFS, 32'h01);
        tx_hold(24'h080000, 30);
        rc(EEF_FLAG_OFS, 32'h0A);
        rc(EEF_STAT_OFS, 32'h82);
        wr(EEF_STCLR_OFS, 32'h12);
        wr(EEF_CLR_OFS, 32'h0A);
        wr(EEF_CTRL_OFS, 32'h05);
        tx_hold(CAUSE[0], 1);
        rc(EEF_FLAG_OFS, 32'h0);
        tx_hold(CAUSE[3], 1);
        rc(EEF_FLAG_OFS, 32'h0A);
        wr(EEF_CLR_OFS, 32'h0A);
        wr(EEF_CTRL_OFS, 32'h0D);
        tx_hold(CAUSE[3], 1);
        tx_hold(24'h800000, 1);
        rc(EEF_FLAG_OFS, 32'h08);
        wr(EEF_CLR_OFS, 32'h08);
        wr(EEF_CTRL_OFS, 32'h1);
        wr(EEF_CTRL_OFS, 32'h0);
        rc(EEF_FLAG_OFS, 32'h08);
        wr(EEF_CLR_OFS, 32'h08);
        chk("status writes", 32'h6, n_stat);
        pin(1'h1);
        rx_frame(1'h0);
        pin(1'h0);
        rx_frame(1'h1);
        rc(EEF_FLAG_OFS, 32'h41);
        wr(EEF_CLR_OFS, 32'h40);
        rc(EEF_FLAG_OFS, 32'h41);
        wr(EEF_PKT_OFS, 32'h1);
        rc(EEF_FLAG_OFS, 32'h01);
        wr(EEF_CLR_OFS, 32'h01);
        phy_pulse();
        rc(EEF_FLAG_OFS, 32'h0);
        wr(EEF_PHYEN_OFS, 32'h12);
        phy_pulse();
        wr(EEF_CLR_OFS, 32'h10);
        rc(EEF_FLAG_OFS, 32'h10);
        rc(EEF_PHYFLAG_OFS, 32'h14);
        rc(EEF_FLAG_OFS, 32'h0);
        repeat (255) rx_frame(1'h0);
        rx_frame(1'h0);
        rc(EEF_PKT_OFS, 32'hFF);
        rc(EEF_FLAG_OFS, 32'h41);
        chk("dropped frames", 32'h2, n_drop);
        fork
            wr(EEF_CLR_OFS, 32'h01);
            begin
                @(posedge aclk);
                rx_frame(1'h1);
            end
        join
        rc(EEF_FLAG_OFS, 32'h41);
        complete_run;
    end
endmodule // eef_event_flags_bench
`default_nettype wire
